// ---- hdl/rxscc_config.sv ----
// Purpose: receiver sof sync and correlator setup registers with decode
// Assumes: byte register port, one access per cycle, synchronous reset
// Notes:   trim is captured from boot_trim while reset is high
//
// Summary of operation
// - hold sof pattern low byte for frame synchronisation.
// - hold sof pattern high byte, forming the 16-bit pattern with low.
// - bits 7..4 of mode give number of valid pattern bits.
// - bit 3 set: first falling correlation edge defines the bit grid.
// - bit 2 set: final pattern bit is half length.
// - pattern type 0: the low valid-count pattern bits form a burst (all 16 when the count is 0).
// - type 1: each nibble is data plus collision flag; collision ignores data.
// - type 2 resyncs at every byte start bit; type 3 reserved.
// - pre-filter bit averages each group of four samples.
// - square shaping bit makes converter samples more rectangular.
// - grid fixed at correlation maximum when 1, minimum when 0.
// - manchester sense bit picks the logical sense of manchester coding.
// - demod bit 1 selects frequency shift keying.
// - demod bit 0 selects binary phase shift keying.
// - frequency field: 0 is 212, 1 is 424, 2 and 3 are 848 kHz.
// - speed field sets clocks per correlation; value 3 reserved.
// - window bit set gives 32 correlation values, clear gives 64.
// - trim byte loaded at boot; software should leave it alone.
`timescale 1ns/1ps
module rxscc_config
    import rxscc_pkg::*;
(
    input  wire logic                              clk,
    input  wire logic                              reset,
    input  wire logic [rxscc_pkg::DATA_W-1:0]      boot_trim,
    input  wire logic [7:0]                        reg_addr,
    input  wire logic                              reg_wr,
    input  wire logic [rxscc_pkg::DATA_W-1:0]      reg_wdata,
    input  wire logic                              reg_rd,
    output logic      [rxscc_pkg::DATA_W-1:0]      reg_rdata,
    output logic                                   reg_rvalid,
    input  wire logic [rxscc_pkg::DATA_W-1:0]      adc_sample,
    input  wire logic                              adc_valid,
    output logic      [rxscc_pkg::DATA_W-1:0]      cond_sample,
    output logic                                   cond_valid,
    output logic      [rxscc_pkg::DATA_W-1:0]      sof_pattern_high,
    output logic      [rxscc_pkg::DATA_W-1:0]      sof_pattern_low,
    output logic      [3:0]                        sof_valid_bit_count,
    output logic                                   grid_from_falling_edge,
    output logic                                   half_final_pattern_bit,
    output logic      [1:0]                        pattern_interpretation,
    output logic      [rxscc_pkg::PATTERN_W-1:0]   expected_pattern,
    output logic      [rxscc_pkg::PATTERN_W-1:0]   pattern_care,
    output logic                                   resync_each_byte,
    output logic                                   pattern_reserved,
    output logic                                   four_sample_average,
    output logic                                   square_shaping,
    output logic                                   grid_at_peak,
    output logic                                   manchester_sense,
    output logic                                   demod_fsk,
    output logic                                   demod_bpsk,
    output logic                                   subcarrier_212,
    output logic                                   subcarrier_424,
    output logic                                   subcarrier_848,
    output logic      [1:0]                        correlation_clock_count,
    output logic                                   clock_count_reserved,
    output logic      [6:0]                        correlation_window_size,
    output logic      [rxscc_pkg::DATA_W-1:0]      receiver_trim
);
    typedef struct packed {
        logic [DATA_W-1:0] sof_high;
        logic [DATA_W-1:0] sof_low;
        logic [DATA_W-1:0] mode;
        logic [DATA_W-1:0] demod;
        logic [DATA_W-1:0] corr;
        logic [DATA_W-1:0] trim;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
        logic [2:0]        sub_sel;
        logic              spd_rsvd;
        logic [6:0]        win;
    } rxscc_cfg_t;

    rxscc_cfg_t st;
    rxscc_cfg_t next_st;

    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_SOF_HIGH: next_st.sof_high = reg_wdata;
                ADDR_SOF_LOW:  next_st.sof_low  = reg_wdata;
                ADDR_MODE:     next_st.mode = reg_wdata & FULL_WMASK;
                ADDR_DEMOD:    next_st.demod = reg_wdata & DEMOD_WMASK;
                ADDR_CORR:     next_st.corr = reg_wdata & CORR_WMASK;
                // writable, but the boot value should be kept
                ADDR_TRIM:     next_st.trim = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            // reads return the value before a same-cycle write
            next_st.rvalid = 1'b1;
            case (reg_addr)
                ADDR_SOF_HIGH: next_st.rdata = st.sof_high;
                ADDR_SOF_LOW:  next_st.rdata = st.sof_low;
                ADDR_MODE:     next_st.rdata = st.mode;
                ADDR_DEMOD:    next_st.rdata = st.demod;
                ADDR_CORR:     next_st.rdata = st.corr;
                ADDR_TRIM:     next_st.rdata = st.trim;
                default:       next_st.rdata = READ_NONE;
            endcase
        end
        unique case (rxscc_freq_t'(next_st.corr[CORR_FREQ_MSB:CORR_FREQ_LSB]))
            RXSCC_FREQ_212:  next_st.sub_sel = SEL_212;
            RXSCC_FREQ_424:  next_st.sub_sel = SEL_424;
            RXSCC_FREQ_848A,
            RXSCC_FREQ_848B: next_st.sub_sel = SEL_848;
        endcase
        next_st.spd_rsvd = next_st.corr[CORR_SPD_MSB:CORR_SPD_LSB]
                           == SPEED_RSVD;
        next_st.win = next_st.corr[CORR_WIN] ? WIN_SHORT : WIN_LONG;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st.sof_high <= RST_REG;
            st.sof_low  <= RST_REG;
            st.mode     <= RST_REG;
            st.demod    <= RST_REG;
            st.corr     <= RST_REG;
            st.trim     <= boot_trim;
            st.rdata    <= READ_NONE;
            st.rvalid   <= 1'b0;
            st.sub_sel  <= SEL_212;
            st.spd_rsvd <= 1'b0;
            st.win      <= WIN_LONG;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata               = st.rdata;
    assign reg_rvalid              = st.rvalid;
    assign sof_pattern_high        = st.sof_high;
    assign sof_pattern_low         = st.sof_low;
    assign sof_valid_bit_count     = st.mode[MODE_LEN_MSB:MODE_LEN_LSB];
    assign grid_from_falling_edge  = st.mode[MODE_NEG_EDGE];
    assign half_final_pattern_bit  = st.mode[MODE_HALF];
    assign pattern_interpretation  = st.mode[MODE_TYPE_MSB:MODE_TYPE_LSB];
    assign four_sample_average     = st.demod[DEMOD_AVG];
    assign square_shaping          = st.demod[DEMOD_SQUARE];
    assign grid_at_peak            = st.demod[DEMOD_PEAK];
    // sense 1 is taken as the inverse of subcarrier then no subcarrier
    assign manchester_sense        = st.demod[DEMOD_SENSE];
    assign demod_fsk               = st.demod[DEMOD_FSK];
    assign demod_bpsk              = st.demod[DEMOD_BPSK];
    assign subcarrier_212          = st.sub_sel[0];
    assign subcarrier_424          = st.sub_sel[1];
    assign subcarrier_848          = st.sub_sel[2];
    assign correlation_clock_count = st.corr[CORR_SPD_MSB:CORR_SPD_LSB];
    assign clock_count_reserved    = st.spd_rsvd;
    assign correlation_window_size = st.win;
    assign receiver_trim           = st.trim;

    rxscc_pattern u_pattern (
        .clk           (clk),
        .reset         (reset),
        .sof_high      (st.sof_high),
        .sof_low       (st.sof_low),
        .valid_count   (st.mode[MODE_LEN_MSB:MODE_LEN_LSB]),
        .interp        (st.mode[MODE_TYPE_MSB:MODE_TYPE_LSB]),
        .expected      (expected_pattern),
        .care          (pattern_care),
        .resync_byte   (resync_each_byte),
        .type_reserved (pattern_reserved)
    );

    rxscc_sample u_sample (
        .clk        (clk),
        .reset      (reset),
        .avg_en     (st.demod[DEMOD_AVG]),
        .square_en  (st.demod[DEMOD_SQUARE]),
        .in_sample  (adc_sample),
        .in_valid   (adc_valid),
        .out_sample (cond_sample),
        .out_valid  (cond_valid)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence wr_to(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence

    sequence mode_wr(logic [1:0] t);
        reg_wr && reg_addr == ADDR_MODE &&
            reg_wdata[MODE_TYPE_MSB:MODE_TYPE_LSB] == t;
    endsequence

    // burst type with a zero count, so every pattern bit must be cared
    sequence burst_all_wr;
        reg_wr && reg_addr == ADDR_MODE &&
            reg_wdata[MODE_TYPE_MSB:MODE_TYPE_LSB] == RXSCC_BURST &&
            reg_wdata[MODE_LEN_MSB:MODE_LEN_LSB] == LEN_ALL;
    endsequence

    sequence quiet_mode;
        !(reg_wr && reg_addr == ADDR_MODE);
    endsequence

    low_byte_a: assert property (
        wr_to(ADDR_SOF_LOW) |=> sof_pattern_low == $past(reg_wdata))
        else $error("low pattern byte not stored");

    high_byte_a: assert property (
        wr_to(ADDR_SOF_HIGH) |=> sof_pattern_high == $past(reg_wdata))
        else $error("high pattern byte not stored");

    bit_count_a: assert property (
        wr_to(ADDR_MODE) |=> sof_valid_bit_count ==
            $past(reg_wdata[MODE_LEN_MSB:MODE_LEN_LSB]))
        else $error("valid bit count wrong");

    falling_grid_a: assert property (
        wr_to(ADDR_MODE) |=> grid_from_falling_edge ==
            $past(reg_wdata[MODE_NEG_EDGE]))
        else $error("falling edge grid flag wrong");

    half_bit_a: assert property (
        wr_to(ADDR_MODE) |=> half_final_pattern_bit ==
            $past(reg_wdata[MODE_HALF]))
        else $error("half final bit flag wrong");

    burst_all_a: assert property (
        burst_all_wr ##1 quiet_mode |=> pattern_care == {PATTERN_W{1'b1}} &&
            !resync_each_byte)
        else $error("burst pattern not fully used");

    nibble_mask_a: assert property (
        mode_wr(RXSCC_NIBBLE) ##1 quiet_mode |=>
            pattern_care[PATTERN_W-1:NIBBLES] == '0 &&
            pattern_care[0] == !$past(sof_pattern_low[NIB_COLL]))
        else $error("nibble collision mask wrong");

    byte_resync_a: assert property (
        mode_wr(RXSCC_BYTE_START) ##1 quiet_mode |=>
            resync_each_byte && !pattern_reserved && pattern_care == '0)
        else $error("byte start resync not selected");

    type_rsvd_a: assert property (
        mode_wr(RXSCC_TYPE_RSVD) ##1 quiet_mode |=>
            pattern_reserved && pattern_care == '0)
        else $error("reserved type not flagged");

    average_bit_a: assert property (
        wr_to(ADDR_DEMOD) |=> four_sample_average ==
            $past(reg_wdata[DEMOD_AVG]))
        else $error("average enable wrong");

    average_rate_a: assert property (
        four_sample_average && cond_valid |=> !cond_valid)
        else $error("averaged output too frequent");

    square_bit_a: assert property (
        wr_to(ADDR_DEMOD) |=> square_shaping ==
            $past(reg_wdata[DEMOD_SQUARE]))
        else $error("square shaping enable wrong");

    peak_grid_a: assert property (
        wr_to(ADDR_DEMOD) |=> grid_at_peak == $past(reg_wdata[DEMOD_PEAK]))
        else $error("grid position select wrong");

    sense_bit_a: assert property (
        wr_to(ADDR_DEMOD) |=> manchester_sense ==
            $past(reg_wdata[DEMOD_SENSE]))
        else $error("manchester sense wrong");

    fsk_select_a: assert property (
        wr_to(ADDR_DEMOD) |=> demod_fsk == $past(reg_wdata[DEMOD_FSK]))
        else $error("fsk select wrong");

    bpsk_select_a: assert property (
        wr_to(ADDR_DEMOD) |=> demod_bpsk == $past(reg_wdata[DEMOD_BPSK]))
        else $error("bpsk select wrong");

    freq_select_a: assert property (
        wr_to(ADDR_CORR) |=>
            (subcarrier_848 == $past(reg_wdata[CORR_FREQ_MSB])) &&
            (subcarrier_424 == ($past(reg_wdata[CORR_FREQ_MSB:CORR_FREQ_LSB])
                                == RXSCC_FREQ_424)) &&
            $onehot({subcarrier_212, subcarrier_424, subcarrier_848}))
        else $error("subcarrier select wrong");

    speed_field_a: assert property (
        wr_to(ADDR_CORR) |=>
            correlation_clock_count ==
                $past(reg_wdata[CORR_SPD_MSB:CORR_SPD_LSB]) &&
            clock_count_reserved == (correlation_clock_count == SPEED_RSVD))
        else $error("correlation speed wrong");

    window_size_a: assert property (
        wr_to(ADDR_CORR) |=> correlation_window_size ==
            ($past(reg_wdata[CORR_WIN]) ? WIN_SHORT : WIN_LONG))
        else $error("correlation window wrong");

    trim_boot_a: assert property (disable iff (1'b0)
        reset ##1 !reset |-> receiver_trim == $past(boot_trim))
        else $error("trim not loaded at boot");

    rsvd_read_a: assert property (
        reg_rd && (reg_addr == ADDR_DEMOD || reg_addr == ADDR_CORR) |=>
            reg_rvalid &&
            (reg_rdata & ($past(reg_addr) == ADDR_DEMOD ?
                          ~DEMOD_WMASK : ~CORR_WMASK)) == '0)
        else $error("reserved bits not zero");
endmodule // rxscc_config

// ---- hdl/rxscc_pattern.sv ----
// Purpose: expands the sof pattern registers into expected bits and care mask
// Assumes: inputs come from the register flops of the parent
// Notes:   one cycle behind the registers
`timescale 1ns/1ps
module rxscc_pattern
    import rxscc_pkg::*;
(
    input  wire logic                               clk,
    input  wire logic                               reset,
    input  wire logic [rxscc_pkg::DATA_W-1:0]       sof_high,
    input  wire logic [rxscc_pkg::DATA_W-1:0]       sof_low,
    input  wire logic [3:0]                         valid_count,
    input  wire logic [1:0]                         interp,
    output logic      [rxscc_pkg::PATTERN_W-1:0]    expected,
    output logic      [rxscc_pkg::PATTERN_W-1:0]    care,
    output logic                                    resync_byte,
    output logic                                    type_reserved
);
    typedef struct packed {
        logic [PATTERN_W-1:0] expected;
        logic [PATTERN_W-1:0] care;
        logic                 resync;
        logic                 rsvd;
    } rxscc_pat_t;

    rxscc_pat_t st;
    rxscc_pat_t next_st;
    logic [PATTERN_W-1:0] word;
    logic [PATTERN_W-1:0] burst_care;
    logic [NIBBLES-1:0]   nib_data;
    logic [NIBBLES-1:0]   nib_care;

    assign word = {sof_high, sof_low};

    genvar i;
    generate
        for (i = 0; i < PATTERN_W; i++) begin : g_bit
            // a zero count means every bit of the pattern is in use
            assign burst_care[i] = (valid_count == LEN_ALL) ||
                                   (i < int'(valid_count));
        end
        for (i = 0; i < NIBBLES; i++) begin : g_nib
            assign nib_data[i] = word[4*i+NIB_DATA];
            assign nib_care[i] = !word[4*i+NIB_COLL];
        end
    endgenerate

    always_comb begin
        next_st = st;
        unique case (rxscc_sync_t'(interp))
            RXSCC_BURST: begin
                next_st.expected = word;
                next_st.care     = burst_care;
                next_st.resync   = 1'b0;
                next_st.rsvd     = 1'b0;
            end
            RXSCC_NIBBLE: begin
                next_st.expected = {{(PATTERN_W-NIBBLES){1'b0}}, nib_data};
                next_st.care     = {{(PATTERN_W-NIBBLES){1'b0}}, nib_care};
                next_st.resync   = 1'b0;
                next_st.rsvd     = 1'b0;
            end
            RXSCC_BYTE_START: begin
                next_st.expected = '0;
                next_st.care     = '0;
                next_st.resync   = 1'b1;
                next_st.rsvd     = 1'b0;
            end
            RXSCC_TYPE_RSVD: begin
                // reserved: nothing is matched so a bad setup cannot lock
                next_st.expected = '0;
                next_st.care     = '0;
                next_st.resync   = 1'b0;
                next_st.rsvd     = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expected      = st.expected;
    assign care          = st.care;
    assign resync_byte   = st.resync;
    assign type_reserved = st.rsvd;
endmodule // rxscc_pattern

// ---- hdl/rxscc_pkg.sv ----
// Purpose: constants and types for the receiver sync and correlator setup
// Assumes: byte-wide register port, byte addresses as printed
// Notes:   reset values of the setup registers are zero, except trim which loads boot_trim
package rxscc_pkg;
    localparam int         DATA_W        = 8;
    localparam int         PATTERN_W     = 16;
    localparam int         NIBBLES       = 4;
    localparam logic [7:0] ADDR_SOF_HIGH = 8'h5a;
    localparam logic [7:0] ADDR_SOF_LOW  = 8'h5b;
    localparam logic [7:0] ADDR_MODE     = 8'h5c;
    localparam logic [7:0] ADDR_DEMOD    = 8'h5d;
    localparam logic [7:0] ADDR_CORR     = 8'h5e;
    localparam logic [7:0] ADDR_TRIM     = 8'h5f;
    localparam logic [7:0] RST_REG       = 8'h00;
    localparam logic [7:0] READ_NONE     = 8'h00;
    localparam logic [7:0] FULL_WMASK    = 8'hff;
    localparam logic [7:0] DEMOD_WMASK   = 8'h3f;
    localparam logic [7:0] CORR_WMASK    = 8'hf8;
    // sof_pattern_mode fields
    localparam int MODE_LEN_MSB  = 7;
    localparam int MODE_LEN_LSB  = 4;
    localparam int MODE_NEG_EDGE = 3;
    localparam int MODE_HALF     = 2;
    localparam int MODE_TYPE_MSB = 1;
    localparam int MODE_TYPE_LSB = 0;
    // receive_demod_mode fields
    localparam int DEMOD_AVG     = 5;
    localparam int DEMOD_SQUARE  = 4;
    localparam int DEMOD_PEAK    = 3;
    localparam int DEMOD_SENSE   = 2;
    localparam int DEMOD_FSK     = 1;
    localparam int DEMOD_BPSK    = 0;
    // correlator_setup fields
    localparam int CORR_FREQ_MSB = 7;
    localparam int CORR_FREQ_LSB = 6;
    localparam int CORR_SPD_MSB  = 5;
    localparam int CORR_SPD_LSB  = 4;
    localparam int CORR_WIN      = 3;
    // nibble layout in pattern mode 1: {data, coll}
    localparam int NIB_DATA      = 1;
    localparam int NIB_COLL      = 0;
    typedef enum logic [1:0] {
        RXSCC_BURST, RXSCC_NIBBLE, RXSCC_BYTE_START, RXSCC_TYPE_RSVD
    } rxscc_sync_t;
    typedef enum logic [1:0] {
        RXSCC_FREQ_212, RXSCC_FREQ_424, RXSCC_FREQ_848A, RXSCC_FREQ_848B
    } rxscc_freq_t;
    localparam logic [1:0] SPEED_RSVD   = 2'h3;
    localparam logic [3:0] LEN_ALL      = 4'h0;
    localparam logic [2:0] SEL_212      = 3'h1;
    localparam logic [2:0] SEL_424      = 3'h2;
    localparam logic [2:0] SEL_848      = 3'h4;
    localparam logic [6:0] WIN_SHORT    = 7'h20;
    localparam logic [6:0] WIN_LONG     = 7'h40;
    localparam logic [1:0] AVG_LAST     = 2'h3;
    localparam int         AVG_SHIFT    = 2;
    localparam int         SUM_W        = 10;
    localparam logic [7:0] SAMPLE_MID   = 8'h80;
    localparam logic [7:0] SAMPLE_MAX   = 8'hff;
endpackage

// ---- hdl/rxscc_sample.sv ----
// Purpose: optional four-sample average and square shaping of converter data
// Assumes: one sample per in_valid pulse
// Notes:   partial groups are dropped when averaging is switched off
`timescale 1ns/1ps
module rxscc_sample
    import rxscc_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           reset,
    input  wire logic                           avg_en,
    input  wire logic                           square_en,
    input  wire logic [rxscc_pkg::DATA_W-1:0]   in_sample,
    input  wire logic                           in_valid,
    output logic      [rxscc_pkg::DATA_W-1:0]   out_sample,
    output logic                                out_valid
);
    typedef struct packed {
        logic [SUM_W-1:0]  sum;
        logic [1:0]        cnt;
        logic [DATA_W-1:0] out;
        logic              vld;
    } rxscc_smp_t;

    rxscc_smp_t st;
    rxscc_smp_t next_st;
    logic [SUM_W-1:0] total;

    // push the value away from mid scale toward the rails
    function automatic logic [DATA_W-1:0] shape(logic [DATA_W-1:0] s,
                                                logic en);
        if (!en)
            return s;
        if (s >= SAMPLE_MID)
            return s + ((SAMPLE_MAX - s) >> 1);
        return s >> 1;
    endfunction

    assign total = st.sum + {2'h0, in_sample};

    always_comb begin
        next_st = st;
        next_st.vld = 1'b0;
        if (in_valid) begin
            if (avg_en) begin
                if (st.cnt == AVG_LAST) begin
                    next_st.out = shape(total[SUM_W-1:AVG_SHIFT],
                                        square_en);
                    next_st.vld = 1'b1;
                    next_st.sum = '0;
                    next_st.cnt = '0;
                end else begin
                    next_st.sum = total;
                    next_st.cnt = st.cnt + 2'h1;
                end
            end else begin
                next_st.out = shape(in_sample, square_en);
                next_st.vld = 1'b1;
                next_st.sum = '0;
                next_st.cnt = '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign out_sample = st.out;
    assign out_valid  = st.vld;
endmodule // rxscc_sample

// ---- verification/rxscc_card_model.sv ----
// Purpose: far-side source of converter samples for the receiver setup
// Assumes: steady subcarrier level while the card answers
// Notes:   valid every cycle while answering; data inverted when silent
`timescale 1ns/1ps
module rxscc_card_model (
    input  wire logic       clk,
    input  wire logic       answer,
    input  wire logic [7:0] level,
    output logic      [7:0] adc_sample,
    output logic            adc_valid
);
    always_ff @(posedge clk) begin
        adc_valid  <= answer;
        // silent line is not a held value, so flip it
        adc_sample <= answer ? level : ~adc_sample;
    end
endmodule // rxscc_card_model

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for rxscc_config
// Assumes: 10 MHz clock, synchronous reset held two cycles
// Notes:   register rows first, then decode and sample path cases
`timescale 1ns/1ps
module tb_top;
    import rxscc_pkg::*;
    logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, answer = 0, adc_valid;
    logic [7:0] reg_addr = 0, reg_wdata = 0, level = 0, adc_sample, rdata;
    logic [7:0] reg_rdata, cond_sample, trim, sh, sl;
    logic [3:0] cnt;
    logic [1:0] intp, ccc;
    logic [15:0] exp_p, care;
    logic [6:0] win;
    logic rvalid, cvalid, neg, half, rsb, prs, avg, sq, pk, ms, fsk, bpsk;
    logic s212, s424, s848, crs;
    int err_count = 0, total_checks = 0, cyc = 0;
    logic [7:0] rows [7][3] = '{'{8'h5a, 8'hff, 8'hff}, '{8'h5b, 8'ha5, 8'ha5},
        '{8'h5c, 8'h3e, 8'h3e}, '{8'h5d, 8'hff, 8'h3f},
        '{8'h5e, 8'hff, 8'hf8}, '{8'h5f, 8'h12, 8'h12},
        '{8'h40, 8'hff, 8'h00}};
    rxscc_card_model rxscc_card_model_inst (.clk(clk), .answer(answer),
        .level(level), .adc_sample(adc_sample), .adc_valid(adc_valid));
    rxscc_config rxscc_config_inst (.clk(clk), .reset(reset),
        .boot_trim(8'h6c), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(rvalid), .adc_sample(adc_sample), .adc_valid(adc_valid),
        .cond_sample(cond_sample), .cond_valid(cvalid), .sof_pattern_high(sh),
        .sof_pattern_low(sl), .sof_valid_bit_count(cnt),
        .grid_from_falling_edge(neg), .half_final_pattern_bit(half),
        .pattern_interpretation(intp), .expected_pattern(exp_p),
        .pattern_care(care), .resync_each_byte(rsb), .pattern_reserved(prs),
        .four_sample_average(avg), .square_shaping(sq), .grid_at_peak(pk),
        .manchester_sense(ms), .demod_fsk(fsk), .demod_bpsk(bpsk),
        .subcarrier_212(s212), .subcarrier_424(s424), .subcarrier_848(s848),
        .correlation_clock_count(ccc), .clock_count_reserved(crs),
        .correlation_window_size(win), .receiver_trim(trim));
    initial forever #50 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk) reg_wr <= 0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk) reg_rd <= 0;
        // rvalid stands one cycle only, so look just after the taking edge
        #1 d = rvalid === 1'b1 ? reg_rdata : 8'hxx;
    endtask
    task automatic sample(input logic [7:0] l, e);
        @(posedge clk) {answer, level} <= {1'b1, l};
        for (int i = 0; i < 12 && cvalid !== 1'b1; i++) @(posedge clk) #1;
        chk("cond", cond_sample, e);
        @(posedge clk) answer <= 0;
        repeat (3) @(posedge clk);
    endtask
    always @(posedge clk) if (++cyc == 3000) begin
        err_count++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 0;
        #1 chk("trim_boot", trim, 8'h6c);
        chk("win_reset", win, WIN_LONG);
        foreach (rows[i]) begin
            wr(rows[i][0], rows[i][1]);
            rd(rows[i][0], rdata);
            chk("reg", rdata, rows[i][2]);
        end
        @(posedge clk) #1;
        chk("pattern", {sh, sl}, 16'hffa5);
        chk("mode", {cnt, neg, half, intp, rsb, care},
            25'h7d_0000);
        chk("demod", {avg, sq, pk, ms, fsk, bpsk},
            6'h3f);
        chk("corr", {ccc, crs, win}, {3'h7, WIN_SHORT});
        wr(8'h5c, 8'h30);
        @(posedge clk) #1 chk("burst", {exp_p, care}, 32'hffa5_0007);
        wr(8'h5c, 8'h03);
        @(posedge clk) #1 chk("rsvd", {prs, care}, 17'h1_0000);
        wr(8'h5c, 8'h01);
        @(posedge clk) #1 chk("nib", {exp_p, care}, 32'h000e_0002);
        wr(8'h5c, 8'h00);
        @(posedge clk) #1 chk("burst_all", care, 16'hffff);
        for (int f = 0; f < 4; f++) begin
            wr({f[1:0], 6'h00}, 8'h00);
            wr(8'h5e, {f[1:0], 6'h00});
            chk("freq", {s848, s424, s212}, f == 0 ? 1 : f == 1 ? 2 : 4);
        end
        sample(8'hc0, 8'hdf);
        wr(8'h5d, 8'h10);
        sample(8'h40, 8'h20);
        complete_run();
    end
endmodule // tb_top
